// ==== logic/apt_pkg.sv ====
// Shared constants of the phase-correct PWM timer with crystal clocking.
package apt_pkg;

  // ==========================================================================
  // Register map (byte addresses on the APB bus).
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_CMPA = 8'h08;
  localparam logic [7:0] ADDR_CMPB = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;

  // ==========================================================================
  // Field positions and widths.
  localparam int CTRL_W = 11;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ACTA_LSB = 4;
  localparam int CTRL_ACTB_LSB = 6;
  localparam int CTRL_CS_LSB = 8;
  localparam int STATUS_ASYNC_BIT = 0;
  localparam int STATUS_BUSY_LSB = 1;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMPA = 1;
  localparam int FLAG_CMPB = 2;

  // Temporary register slots, one per asynchronously updated register.
  localparam int SLOTS = 4;
  localparam int SLOT_COUNT = 0;
  localparam int SLOT_CMPA = 1;
  localparam int SLOT_CMPB = 2;
  localparam int SLOT_CTRL = 3;

  // ==========================================================================
  // Reset values.
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'h00;

  // ==========================================================================
  // Modes, output actions and counter limits.
  localparam logic [2:0] MODE_PC_FIXED = 3'h1;
  localparam logic [2:0] MODE_PC_CMPA = 3'h5;
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_NONINV = 2'h2;
  localparam logic [1:0] ACT_INV = 2'h3;
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] MAX = 8'hff;

  // ==========================================================================
  // Timing: crystal edges per transfer and prescale divisors (0 stops).
  localparam logic [1:0] XFER_EDGES = 2'h2;
  localparam logic [10:0] PRESCALE_DIV [0:7] = '{11'h000, 11'h001, 11'h008, 11'h020,
                                                 11'h040, 11'h080, 11'h100, 11'h400};

endpackage

// ==== logic/apt_tick_gen.sv ====
// Crystal pin synchroniser and prescaler that make the timer clock tick.
`timescale 1ns/1ps
module apt_tick_gen
  import apt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic crystal_clock_in_i,
  input wire logic async_sel_i,
  input wire logic [2:0] clk_sel_i,
  output logic xedge_o,
  output logic tick_o
);

  logic [2:0] xsync_q;
  logic [9:0] pre_q;
  logic base_w;
  logic [10:0] div_w;
  logic wrap_w;

  // ==========================================================================
  // Two-flop synchroniser plus one history flop for the rising edge.
  // The crystal keeps being sampled in any state of the rest of the system except reset, which holds the flops at zero.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      xsync_q <= 3'h0;
    else
      xsync_q <= {xsync_q[1:0], crystal_clock_in_i};
  end

  // Rising crystal edge, seen only from the second and third flops.
  assign xedge_o = xsync_q[1] & ~xsync_q[2];

  // ==========================================================================
  // Source select and divide; a divisor of zero stops the timer.
  assign base_w = async_sel_i ? xedge_o : 1'b1;
  assign div_w = PRESCALE_DIV[clk_sel_i];
  assign wrap_w = (pre_q == 10'(div_w - 11'h001));
  assign tick_o = base_w && (div_w != 11'h000) && wrap_w;

  // Prescale counter, restarted at each tick.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      pre_q <= 10'h000;
    else if (div_w == 11'h000)
      pre_q <= 10'h000;
    else if (base_w)
      pre_q <= wrap_w ? 10'h000 : pre_q + 10'h001;
  end

endmodule

// ==== logic/apt_timer.sv ====
// Phase-correct PWM timer with crystal clocking, temporary write registers and APB access.
`timescale 1ns/1ps
// Notes on behaviour
// - Modes 1 and 5 count up from BOTTOM to TOP, then back down, repeatedly.
// - Phase-correct TOP is either fixed 0xFF or the compare A value.
// - Action 2 clears on up-match, sets on down-match; action 3 inverts both.
// - Counter holds TOP for one timer clock, then counts down.
// - Overflow flag sets each time the counter reaches BOTTOM.
// - Output period is 510 prescaled timer clocks at TOP 0xFF.
// - Compare at BOTTOM gives constant low, at MAX constant high (non-inverted).
// - Output moves at BOTTOM without match to keep the waveform symmetric.
// - Compare equal to TOP with upper action bit set acts at TOP instead.
// - Async select clocks the counter from the crystal and detaches its pins.
// - Writes go to a temporary register, latched after two crystal edges, busy meanwhile.
// - Pending counter or compare write disables compare matches and their flags.
// - Counter advances at least one step before software can read it after an event.
// - Counter read copy refreshes on each rising crystal edge.
// - Flags reach software after synchroniser cycles plus one timer cycle.
// - Compare output changes on the timer tick, not on software timing.
// - Crystal sampling stops only while in reset; register contents are lost only on reset.
module apt_timer
  import apt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic crystal_clock_in_i,
  output logic xtal_port_detach_o,
  output logic [1:0] compare_output_o,
  output logic [1:0] compare_output_oe_o
);

  // ==========================================================================
  // Declarations.
  logic async_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic dir_up_q;
  logic dir_d;
  logic [7:0] cnt_rd_q;
  logic [7:0] cmp_q [2];
  logic [2:0] flags_q;
  logic [31:0] prdata_q;
  logic pend_q [SLOTS];
  logic [1:0] xcnt_q [SLOTS];
  logic [CTRL_W-1:0] temp_q [SLOTS];
  logic wr_slot_w [SLOTS];
  logic xfer_w [SLOTS];
  logic [1:0] out_q;
  logic [1:0] match_w;
  logic xedge_w;
  logic tick_w;
  logic wr_w;
  logic setup_w;
  logic access_w;
  logic addr_hit_w;
  logic [2:0] mode_w;
  logic pc_mode_w;
  logic [7:0] top_w;
  logic ovf_ev_w;
  logic [3:0] busy_w;
  logic [31:0] rd_data_w;

  // Byte address of each temporary register slot.
  function automatic logic [7:0] slot_addr(input int s);
    logic [7:0] a;
    a = ADDR_CTRL;
    case (s)
      SLOT_COUNT: a = ADDR_COUNT;
      SLOT_CMPA: a = ADDR_CMPA;
      SLOT_CMPB: a = ADDR_CMPB;
      default: a = ADDR_CTRL;
    endcase
    return a;
  endfunction

  // ==========================================================================
  // Timer clock source.
  apt_tick_gen u_tick (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .crystal_clock_in_i(crystal_clock_in_i),
    .async_sel_i(async_q),
    .clk_sel_i(ctrl_q[CTRL_CS_LSB +: 3]),
    .xedge_o(xedge_w),
    .tick_o(tick_w)
  );

  // Pins of the crystal leave their port function while async is on.
  assign xtal_port_detach_o = async_q;

  // ==========================================================================
  // APB decode; the slave answers with no wait state.
  assign setup_w = psel_i && !penable_i;
  assign access_w = psel_i && penable_i;
  assign wr_w = access_w && pwrite_i;
  assign addr_hit_w = (paddr_i == ADDR_CTRL) || (paddr_i == ADDR_COUNT) || (paddr_i == ADDR_CMPA) ||
                      (paddr_i == ADDR_CMPB) || (paddr_i == ADDR_STATUS) || (paddr_i == ADDR_FLAGS);
  assign pready_o = 1'b1;
  assign pslverr_o = access_w && !addr_hit_w;
  assign prdata_o = prdata_q;

  // Read selection; busy bits and the resynchronised counter copy show state.
  assign busy_w = {pend_q[SLOT_CTRL], pend_q[SLOT_CMPB], pend_q[SLOT_CMPA], pend_q[SLOT_COUNT]};
  assign rd_data_w = (paddr_i == ADDR_CTRL) ? {21'h000000, ctrl_q} :
                     (paddr_i == ADDR_COUNT) ? {24'h000000, cnt_rd_q} :
                     (paddr_i == ADDR_CMPA) ? {24'h000000, cmp_q[0]} :
                     (paddr_i == ADDR_CMPB) ? {24'h000000, cmp_q[1]} :
                     (paddr_i == ADDR_STATUS) ? {27'h0000000, busy_w, async_q} :
                     (paddr_i == ADDR_FLAGS) ? {29'h00000000, flags_q} : 32'h00000000;

  // Read data is captured in the setup cycle and held through the access.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      prdata_q <= 32'h00000000;
    else if (setup_w && !pwrite_i)
      prdata_q <= rd_data_w;
  end

  // Async select is written directly, not through a temporary register.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      async_q <= 1'b0;
    else if (wr_w && paddr_i == ADDR_STATUS)
      async_q <= pwdata_i[STATUS_ASYNC_BIT];
  end

  // ==========================================================================
  // Temporary registers; in async mode a value moves after two crystal edges.
  // A second write while busy restarts the wait with the newer value.
  for (genvar s = 0; s < SLOTS; s++)
  begin : g_slot
    assign wr_slot_w[s] = wr_w && (paddr_i == slot_addr(s));
    assign xfer_w[s] = pend_q[s] && !wr_slot_w[s] &&
                       (!async_q || (xedge_w && xcnt_q[s] == XFER_EDGES - 2'h1));
    always_ff @(posedge clk_sys_i)
    begin
      if (rst_i)
      begin
        pend_q[s] <= 1'b0;
        xcnt_q[s] <= 2'h0;
        temp_q[s] <= CTRL_RESET;
      end
      else if (wr_slot_w[s])
      begin
        pend_q[s] <= 1'b1;
        xcnt_q[s] <= 2'h0;
        temp_q[s] <= pwdata_i[CTRL_W-1:0];
      end
      else if (xfer_w[s])
        pend_q[s] <= 1'b0;
      else if (pend_q[s] && async_q && xedge_w)
        xcnt_q[s] <= xcnt_q[s] + 2'h1;
    end
  end

  // Control register destination.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      ctrl_q <= CTRL_RESET;
    else if (xfer_w[SLOT_CTRL])
      ctrl_q <= temp_q[SLOT_CTRL];
  end

  // ==========================================================================
  // Mode and TOP selection.
  assign mode_w = ctrl_q[CTRL_MODE_LSB +: 3];
  assign pc_mode_w = (mode_w == MODE_PC_FIXED) || (mode_w == MODE_PC_CMPA);
  assign top_w = (mode_w == MODE_PC_CMPA) ? cmp_q[0] : MAX;

  // Dual-slope count: TOP is held for one tick, BOTTOM turns upward again.
  // A full period at TOP 0xFF is 2 x 255 = 510 ticks.
  always_comb
  begin
    cnt_d = cnt_q;
    dir_d = dir_up_q;
    if (xfer_w[SLOT_COUNT])
      cnt_d = temp_q[SLOT_COUNT][7:0];
    else if (tick_w && pc_mode_w)
    begin
      if (dir_up_q && cnt_q >= top_w)
      begin
        dir_d = 1'b0;
        cnt_d = (cnt_q == BOTTOM) ? BOTTOM : cnt_q - 8'h01;
      end
      else if (dir_up_q)
        cnt_d = cnt_q + 8'h01;
      else if (cnt_q == BOTTOM)
      begin
        dir_d = 1'b1;
        cnt_d = (top_w == BOTTOM) ? BOTTOM : cnt_q + 8'h01;
      end
      else
        cnt_d = cnt_q - 8'h01;
    end
    else if (tick_w)
    begin
      dir_d = 1'b1;
      cnt_d = cnt_q + 8'h01;
    end
  end

  // Counter and its direction; both step on the timer tick.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      cnt_q <= COUNT_RESET;
      dir_up_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      dir_up_q <= dir_d;
    end
  end

  // Software copy refreshed on each rising crystal edge in async mode.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      cnt_rd_q <= COUNT_RESET;
    else if (!async_q || xedge_w)
      cnt_rd_q <= cnt_q;
  end

  // ==========================================================================
  // Overflow event: BOTTOM in phase-correct modes, wrap from MAX otherwise.
  assign ovf_ev_w = tick_w && (pc_mode_w ? (!dir_up_q && cnt_q == BOTTOM) : (cnt_q == MAX));

  // Compare channels: match, flag cause and output waveform.
  for (genvar g = 0; g < 2; g++)
  begin : g_cmp
    logic [1:0] act_w;
    logic res_up_w;
    logic res_dn_w;
    logic top_case_w;
    logic bottom_w;
    logic blocked_w;
    assign act_w = ctrl_q[(g == 0 ? CTRL_ACTA_LSB : CTRL_ACTB_LSB) +: 2];
    assign blocked_w = pend_q[SLOT_COUNT] || pend_q[g == 0 ? SLOT_CMPA : SLOT_CMPB];
    assign match_w[g] = tick_w && !blocked_w && (cnt_q == cmp_q[g]);
    assign res_up_w = act_w[0];
    assign res_dn_w = ~act_w[0];
    assign top_case_w = pc_mode_w && act_w[1] && cmp_q[g] == top_w && cnt_q == top_w && dir_up_q;
    assign bottom_w = tick_w && pc_mode_w && act_w[1] && cnt_q == BOTTOM && !dir_up_q;
    assign compare_output_oe_o[g] = (act_w != ACT_OFF);
    assign compare_output_o[g] = out_q[g];

    // Compare register destination.
    always_ff @(posedge clk_sys_i)
    begin
      if (rst_i)
        cmp_q[g] <= CMP_RESET;
      else if (xfer_w[g == 0 ? SLOT_CMPA : SLOT_CMPB])
        cmp_q[g] <= temp_q[g == 0 ? SLOT_CMPA : SLOT_CMPB][7:0];
    end

    // Output register, changed only on timer ticks.
    always_ff @(posedge clk_sys_i)
    begin
      if (rst_i)
        out_q[g] <= 1'b0;
      else if (tick_w && top_case_w)
        out_q[g] <= res_dn_w;
      else if (match_w[g] && pc_mode_w && act_w[1])
        out_q[g] <= (dir_up_q || cnt_q == BOTTOM) ? res_up_w : res_dn_w;
      else if (bottom_w)
        out_q[g] <= (cmp_q[g] == BOTTOM) ? res_up_w : res_dn_w;
      else if (match_w[g] && !pc_mode_w && act_w != ACT_OFF)
        out_q[g] <= (act_w == ACT_TOGGLE) ? ~out_q[g] : (act_w == ACT_INV);
    end
  end

  // ==========================================================================
  // Sticky flags; write one to clear, a new event in the same cycle wins.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      flags_q <= 3'h0;
    else
      flags_q <= (flags_q & ~((wr_w && paddr_i == ADDR_FLAGS) ? pwdata_i[2:0] : 3'h0)) |
                 {match_w[1], match_w[0], ovf_ev_w};
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_top_turn;
    tick_w && pc_mode_w && dir_up_q && cnt_q == top_w && top_w != BOTTOM && !xfer_w[SLOT_COUNT]
      |=> !dir_up_q && cnt_q == $past(top_w) - 8'h01;
  endproperty
  a_top_turn: assert property (p_top_turn) else $error("counter did not turn at TOP");

  property p_bottom_turn;
    tick_w && pc_mode_w && !dir_up_q && cnt_q == BOTTOM && top_w != BOTTOM && !xfer_w[SLOT_COUNT]
      |=> dir_up_q && cnt_q == 8'h01;
  endproperty
  a_bottom_turn: assert property (p_bottom_turn) else $error("counter did not turn at BOTTOM");

  property p_top_select;
    (mode_w == MODE_PC_CMPA |-> top_w == cmp_q[0]) and (mode_w == MODE_PC_FIXED |-> top_w == MAX);
  endproperty
  a_top_select: assert property (p_top_select) else $error("wrong TOP for mode");

  property p_ovf_at_bottom;
    pc_mode_w && tick_w && !dir_up_q && cnt_q == BOTTOM |=> flags_q[FLAG_OVF];
  endproperty
  a_ovf_at_bottom: assert property (p_ovf_at_bottom) else $error("overflow flag missed at BOTTOM");

  property p_up_clear;
    pc_mode_w && match_w[0] && dir_up_q && cnt_q != BOTTOM && ctrl_q[CTRL_ACTA_LSB +: 2] == ACT_NONINV &&
      cmp_q[0] != top_w |=> compare_output_o[0] == 1'b0;
  endproperty
  a_up_clear: assert property (p_up_clear) else $error("up-count match did not clear");

  property p_busy_wait;
    async_q && pend_q[SLOT_CMPA] && !xedge_w |=> pend_q[SLOT_CMPA];
  endproperty
  a_busy_wait: assert property (p_busy_wait) else $error("busy cleared without crystal edge");

  property p_no_match_pending;
    (pend_q[SLOT_COUNT] || pend_q[SLOT_CMPA]) |-> !match_w[0];
  endproperty
  a_no_match_pending: assert property (p_no_match_pending) else $error("match during pending write");

  property p_detach;
    xtal_port_detach_o == async_q;
  endproperty
  a_detach: assert property (p_detach) else $error("crystal pins not detached");

  property p_read_copy;
    async_q && !xedge_w ##1 async_q |-> $stable(cnt_rd_q);
  endproperty
  a_read_copy: assert property (p_read_copy) else $error("counter copy changed off edge");

  property p_pin_on_tick;
    !tick_w |=> $stable(compare_output_o);
  endproperty
  a_pin_on_tick: assert property (p_pin_on_tick) else $error("output changed without tick");

  c_top_reached: cover property (tick_w && pc_mode_w && dir_up_q && cnt_q == top_w);
  c_async_xfer: cover property (async_q && xfer_w[SLOT_CMPA]);
  c_bottom_flag: cover property (pc_mode_w && ovf_ev_w);
  c_out_rise: cover property (pc_mode_w && $rose(compare_output_o[0]));

endmodule

// ==== testbench/apt_xtal_model.sv ====
// Crystal oscillator model that clocks the timer's crystal pin.
`timescale 1ns/1ps
module apt_xtal_model #(
  parameter int HALF_NS = 71
)
(
  output logic crystal_clock_o
);
  // ==========================================================================
  // Free-running crystal, slower than a quarter of the system clock.
  initial crystal_clock_o = 1'b0;
  // The oscillator never stops once started, so the pin toggles forever.
  always #(HALF_NS) crystal_clock_o = ~crystal_clock_o;
endmodule

// ==== testbench/async_timer_phase_pwm_bench.sv ====
// Self-checking bench for the phase-correct PWM timer with crystal clocking.
`timescale 1ns/1ps
module async_timer_phase_pwm_bench;
  import apt_pkg::*;
  // ==========================================================================
  // Clock, bus signals and bookkeeping.
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, detach, xtal;
  logic [1:0] outs, oes;
  int errors = 0;
  int n_tests = 0;
  int seed = 5287;
  int exp_q[$];
  int c, t, k, ha, hb, ra, rb, v;
  logic [1:0] ab;
  logic [7:0] regs [6] = '{ADDR_CTRL, ADDR_COUNT, ADDR_CMPA, ADDR_CMPB, ADDR_STATUS, ADDR_FLAGS};

  always #10 clk_sys_i = ~clk_sys_i;

  apt_xtal_model xtal_m (.crystal_clock_o(xtal));

  apt_timer dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .crystal_clock_in_i(xtal), .xtal_port_detach_o(detach),
    .compare_output_o(outs), .compare_output_oe_o(oes));

  // ==========================================================================
  // Verdict, comparison and bus tasks.
  task test_done;
    if (errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the pready edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    @(posedge clk_sys_i);
    while (pready !== 1'b1)
      @(posedge clk_sys_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // Stops the timer, clears the counter and loads a new configuration.
  task setup_pwm(input logic [2:0] m, input logic [1:0] aa, input logic [1:0] bb, input logic [2:0] cs,
                 input logic [7:0] ca, input logic [7:0] cb);
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_COUNT, 32'h0);
    apb(1'b1, ADDR_CMPA, {24'h0, ca});
    apb(1'b1, ADDR_CMPB, {24'h0, cb});
    apb(1'b1, ADDR_CTRL, {21'h0, cs, bb, aa, 1'b0, m});
    // The control value lands one edge after the write ends, at the last edge of apb; one more edge lets the enables settle.
    @(posedge clk_sys_i);
  endtask

  // Counts high cycles and rising edges of both outputs over n cycles.
  task measure(input int n);
    logic [1:0] prev;
    prev = outs;
    ha = 0;
    hb = 0;
    ra = 0;
    rb = 0;
    repeat (n)
    begin
      @(posedge clk_sys_i);
      ha += int'(outs[0] === 1'b1);
      hb += int'(outs[1] === 1'b1);
      ra += int'(outs[0] === 1'b1 && prev[0] === 1'b0);
      rb += int'(outs[1] === 1'b1 && prev[1] === 1'b0);
      prev = outs;
    end
  endtask

  // Reference model: high cycles over two periods and rising edges per two periods.
  task model(input int cv, input int top, input int n, input bit inv);
    exp_q.push_back(4 * (inv ? (top - cv) : cv) * n);
    exp_q.push_back((cv > 0 && cv < top) ? 2 : 0);
  endtask

  // ==========================================================================
  // Watchdog against a hang.
  initial
  begin
    #(2_000_000);
    errors++;
    test_done;
  end

  // ==========================================================================
  // Main sequence.
  initial
  begin
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, regs[i], 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Fixed TOP: both compare extremes, random values, and a /8 prescale.
    for (int i = 0; i < 5; i++)
    begin
      c = (i == 0) ? 0 : (i == 1) ? 255 : 1 + ($unsigned($random(seed)) % 254);
      v = (i == 4) ? 8 : 1;
      setup_pwm(MODE_PC_FIXED, ACT_NONINV, ACT_INV, (i == 4) ? 3'h2 : 3'h1, c[7:0], c[7:0]);
      chk({30'h0, oes}, 32'h3);
      repeat (1020 * v) @(posedge clk_sys_i);
      measure(1020 * v);
      model(c, 255, v, 1'b0);
      model(c, 255, v, 1'b1);
      chk(ha, exp_q.pop_front());
      chk(ra, exp_q.pop_front());
      chk(hb, exp_q.pop_front());
      exp_q.delete();
    end
    // Compare A as TOP on channel B, random polarity.
    t = 40 + ($unsigned($random(seed)) % 160);
    c = 1 + ($unsigned($random(seed)) % (t - 1));
    ab = ($random(seed) & 1) ? ACT_INV : ACT_NONINV;
    setup_pwm(MODE_PC_CMPA, ACT_OFF, ab, 3'h1, t[7:0], c[7:0]);
    chk({30'h0, oes}, 32'h2);
    repeat (4 * t) @(posedge clk_sys_i);
    measure(4 * t);
    model(c, t, 1, ab == ACT_INV);
    chk(hb, exp_q.pop_front());
    chk(rb, exp_q.pop_front());
    apb(1'b0, ADDR_COUNT, 32'h0);
    chk({31'h0, rd <= t}, 32'h1);
    // Overflow flag returns within 200 flag reads after clearing.
    apb(1'b1, ADDR_FLAGS, 32'h7);
    k = 0;
    do
    begin
      apb(1'b0, ADDR_FLAGS, 32'h0);
      k++;
    end
    while (rd[FLAG_OVF] !== 1'b1 && k < 200);
    chk({31'h0, rd[FLAG_OVF]}, 32'h1);
    // Crystal clocking: port detach, busy status and transfer.
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'h1);
    chk({31'h0, detach}, 32'h1);
    v = $unsigned($random(seed)) % 256;
    apb(1'b1, ADDR_CMPB, v);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({31'h0, rd[3]}, 32'h1);
    k = 0;
    do
    begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      k++;
    end
    while (rd[4:1] !== 4'h0 && k < 100);
    chk({28'h0, rd[4:1]}, 32'h0);
    apb(1'b0, ADDR_CMPB, 32'h0);
    chk(rd, v);
    // Clock switch procedure: rewrite counter and control, wait for busy, then clear flags.
    apb(1'b1, ADDR_COUNT, 32'h0);
    apb(1'b1, ADDR_CTRL, {21'h0, 3'h1, 4'h0, 1'b0, MODE_PC_FIXED});
    k = 0;
    do
    begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      k++;
    end
    while (rd[4:1] !== 4'h0 && k < 100);
    chk({28'h0, rd[4:1]}, 32'h0);
    apb(1'b1, ADDR_FLAGS, 32'h7);
    repeat (100) @(posedge clk_sys_i);
    apb(1'b0, ADDR_COUNT, 32'h0);
    v = rd;
    repeat (200) @(posedge clk_sys_i);
    apb(1'b0, ADDR_COUNT, 32'h0);
    chk({31'h0, rd !== v}, 32'h1);
    chk({31'h0, rd > v}, 32'h1);
    test_done;
  end
endmodule
